// >>> hw/pll_clock_config_pkg.sv
// Purpose: shared constants for the clock configuration and supervision block
// Assumes: one system clock at SYS_CLK_MHZ
// Notes:   register offsets are byte addresses on the plain port, field positions are bit numbers
package pll_clock_config_pkg;

  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_MHZ  = 250;
  localparam int LOSS_TIME_NS = 1000;
  // longest wait, so rounded down
  localparam int LOSS_CYCLES  = (LOSS_TIME_NS * SYS_CLK_MHZ) / 1000;
  localparam int PER_W        = 12;
  localparam int DEV_TOL      = 2;
  localparam int LOCK_COUNT   = 4;
  localparam int SETTLE_CYC   = 3;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;

  // config register fields
  localparam int CFG_SEL_LSB  = 0;
  localparam int CFG_BYP_BIT  = 3;
  localparam int CFG_OUTPUT_DIVIDER_SELECT_LSB = 4;
  localparam int CFG_N_LSB    = 8;
  localparam int CFG_LOCK_BIT = 12;
  localparam int CFG_EMER_BIT = 13;
  localparam logic [2:0] OUTPUT_DIVIDER_SELECT_RESET = 3'h0;

  // status / interrupt bits
  localparam int STS_W        = 3;
  localparam int STS_CLK_LOSS = 0;
  localparam int STS_DEVIATE  = 1;
  localparam int STS_LOCK_OFF = 2;

  localparam logic [3:0] N_BASE = 4'h8;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_ACQUIRE,
    ST_LOCKED,
    ST_LOST
  } lock_state_t;

  // output divide factor for each select code
  function automatic logic [4:0] k_factor(input logic [2:0] code);
    case (code)
      3'h0:    k_factor = 5'h02;
      3'h1:    k_factor = 5'h10;
      3'h2:    k_factor = 5'h04;
      3'h3:    k_factor = 5'h05;
      3'h4:    k_factor = 5'h06;
      3'h5:    k_factor = 5'h08;
      3'h6:    k_factor = 5'h09;
      default: k_factor = 5'h0A;
    endcase
  endfunction

  function automatic logic [PER_W-1:0] abs_diff(input logic [PER_W-1:0] a,
                                                 input logic [PER_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

endpackage

// >>> hw/clk_out_divider.sv
// Purpose: divides a tick enable by the output factor into a clock level
// Assumes: tick_i is a one-cycle enable at the source rate
// Notes:   high phase is factor/2 ticks, so odd factors run below half duty
`timescale 1ns/1ns
`default_nettype none
module clk_out_divider
  import pll_clock_config_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] output_divider_select_i,
  output logic            clk_o,
  output logic            clk_en_o
);

  logic [4:0] cnt_r;
  logic [4:0] factor;
  logic [4:0] high_len;

  assign factor   = k_factor(output_divider_select_i);
  assign high_len = factor >> 1;

  // ---------------------------------------------------------------
  // tick counter, restarts on the last tick of a period
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 5'h00;
    end else if (tick_i) begin
      // a factor change mid-period finishes at the new length, or on the next tick if the count is already past it
      if (cnt_r >= factor - 5'h01) begin
        cnt_r <= 5'h00;
      end else begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock level: 5 gives 2 of 5 high, 9 gives 4 of 9 high
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_o    <= 1'b0;
      clk_en_o <= 1'b0;
    end else begin
      clk_en_o <= tick_i && (cnt_r == 5'h00);
      if (tick_i) begin
        clk_o <= (cnt_r < high_len);
      end
    end
  end

endmodule
`default_nettype wire

// >>> hw/pll_clock_config.sv
// Purpose: clock configuration pins, digital loop lock, output divider and fail-safe
// Assumes: oscillator and pins are asynchronous and pass two flip-flops
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pll_clock_config
  import pll_clock_config_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              osc_clk_i,
  input  wire logic [2:0]        pll_multiplier_select_i,
  input  wire logic              bypass_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   irq_o,
  output logic                   sys_clk_o,
  output logic                   sys_clk_en_o,
  output logic                   locked_o,
  output logic                   emergency_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       osc_meta_r;
  logic       osc_sync_r;
  logic       osc_prev_r;
  logic [2:0] sel_meta_r;
  logic [2:0] sel_sync_r;
  logic       byp_meta_r;
  logic       byp_sync_r;
  logic       osc_rise;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
      sel_meta_r <= 3'h0;
      sel_sync_r <= 3'h0;
      byp_meta_r <= 1'b0;
      byp_sync_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_clk_i;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
      sel_meta_r <= pll_multiplier_select_i;
      sel_sync_r <= sel_meta_r;
      byp_meta_r <= bypass_i;
      byp_sync_r <= byp_meta_r;
    end
  end

  assign osc_rise = osc_sync_r & ~osc_prev_r;

  // ---------------------------------------------------------------
  // configuration latch
  // ---------------------------------------------------------------
  // caught after release so the strap has cleared the synchronisers
  logic [1:0] settle_cnt_r;
  logic       cfg_valid_r;
  logic [2:0] cfg_sel_r;
  logic       cfg_byp_r;
  logic [3:0] n_factor_r;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_cnt_r <= 2'h0;
      cfg_valid_r  <= 1'b0;
      cfg_sel_r    <= 3'h0;
      cfg_byp_r    <= 1'b0;
      n_factor_r   <= N_BASE;
    end else if (!cfg_valid_r) begin
      if (settle_cnt_r == 2'(SETTLE_CYC - 1)) begin
        cfg_valid_r <= 1'b1;
        cfg_sel_r   <= sel_sync_r;
        cfg_byp_r   <= byp_sync_r;
        n_factor_r  <= N_BASE + {1'b0, sel_sync_r};
      end else begin
        settle_cnt_r <= settle_cnt_r + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator period measurement
  // ---------------------------------------------------------------
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_last_r;
  logic             clk_gone;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_cnt_r  <= '0;
      per_last_r <= '0;
    end else if (osc_rise) begin
      per_cnt_r  <= PER_W'(1);
      per_last_r <= per_cnt_r;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + PER_W'(1);
    end
  end

  assign clk_gone = (per_cnt_r == PER_W'(LOSS_CYCLES));

  // ---------------------------------------------------------------
  // lock supervision
  // ---------------------------------------------------------------
  lock_state_t      state_r;
  logic [PER_W-1:0] ref_per_r;
  logic [2:0]       stable_cnt_r;
  logic             ev_loss;
  logic             ev_dev;
  logic             ev_unlock;
  logic             lock_drop;

  assign ev_loss   = clk_gone && cfg_valid_r;
  assign ev_dev    = (state_r == ST_LOCKED) && osc_rise
                     && (abs_diff(per_cnt_r, ref_per_r) > PER_W'(DEV_TOL));
  assign lock_drop = (state_r == ST_LOCKED) && (ev_dev || clk_gone);
  assign ev_unlock = lock_drop;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r      <= ST_SETTLE;
      ref_per_r    <= '0;
      stable_cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        ST_SETTLE: begin
          if (cfg_valid_r) begin
            state_r <= ST_ACQUIRE;
          end
        end
        ST_ACQUIRE: begin
          if (osc_rise) begin
            if (abs_diff(per_cnt_r, per_last_r) <= PER_W'(DEV_TOL)) begin
              stable_cnt_r <= stable_cnt_r + 3'h1;
            end else begin
              stable_cnt_r <= 3'h0;
            end
            if (stable_cnt_r == 3'(LOCK_COUNT - 1)) begin
              state_r   <= ST_LOCKED;
              ref_per_r <= per_cnt_r;
            end
          end
        end
        ST_LOCKED: begin
          if (lock_drop) begin
            state_r <= ST_LOST;
          end
        end
        ST_LOST: begin
          stable_cnt_r <= 3'h0;
          if (osc_rise) begin
            state_r <= ST_ACQUIRE;
          end
        end
      endcase
    end
  end

  // emergency holds until the loop locks again
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      emergency_o  <= 1'b0;
      locked_o     <= 1'b0;
    end else begin
      locked_o <= (state_r == ST_LOCKED) && !lock_drop;
      if (lock_drop) begin
        emergency_o <= 1'b1;
      end else if (state_r == ST_LOCKED) begin
        emergency_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // loop tick generator: N ticks per reference period
  // ---------------------------------------------------------------
  logic [PER_W:0] acc_r;
  logic [PER_W:0] acc_sum;
  logic           vco_tick_r;
  logic           use_osc;
  logic           src_tick;

  assign acc_sum = acc_r + {{(PER_W-3){1'b0}}, n_factor_r};

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r      <= '0;
      vco_tick_r <= 1'b0;
    end else if (state_r != ST_LOCKED) begin
      acc_r      <= '0;
      vco_tick_r <= 1'b0;
    end else if (acc_sum >= {1'b0, ref_per_r}) begin
      // saturates at one tick per cycle if the input runs too fast
      acc_r      <= acc_sum - {1'b0, ref_per_r};
      vco_tick_r <= 1'b1;
    end else begin
      acc_r      <= acc_sum;
      vco_tick_r <= 1'b0;
    end
  end

  assign use_osc  = cfg_byp_r || (state_r != ST_LOCKED);
  assign src_tick = use_osc ? (osc_rise && cfg_valid_r) : vco_tick_r;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]       output_divider_select_r;
  logic [STS_W-1:0] sts_r;
  logic [STS_W-1:0] ien_r;
  logic [STS_W-1:0] ev_set;
  logic [STS_W-1:0] clr;
  logic [DATA_W-1:0] rd_mux;

  assign ev_set = {ev_unlock, ev_dev, ev_loss};
  assign clr    = (wr_i && addr_i == OFS_CLEAR) ? wdata_i[STS_W-1:0] : '0;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_divider_select_r <= OUTPUT_DIVIDER_SELECT_RESET;
      ien_r  <= '0;
    end else if (wr_i) begin
      if (addr_i == OFS_CONFIG) begin
        // codes 011 and 110 are accepted; software keeps clear of them
        output_divider_select_r <= wdata_i[CFG_OUTPUT_DIVIDER_SELECT_LSB +: 3];
      end
      if (addr_i == OFS_ENABLE) begin
        ien_r <= wdata_i[STS_W-1:0];
      end
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sts_r <= '0;
    end else begin
      sts_r <= (sts_r & ~clr) | ev_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((sts_r & ~clr) | ev_set) & ien_r);
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      OFS_CONFIG: begin
        rd_mux[CFG_SEL_LSB +: 3]  = cfg_sel_r;
        rd_mux[CFG_BYP_BIT]       = cfg_byp_r;
        rd_mux[CFG_OUTPUT_DIVIDER_SELECT_LSB +: 3] = output_divider_select_r;
        rd_mux[CFG_N_LSB +: 4]    = n_factor_r;
        rd_mux[CFG_LOCK_BIT]      = (state_r == ST_LOCKED);
        rd_mux[CFG_EMER_BIT]      = emergency_o;
      end
      OFS_STATUS: rd_mux[STS_W-1:0] = sts_r;
      OFS_ENABLE: rd_mux[STS_W-1:0] = ien_r;
      OFS_PERIOD: rd_mux[PER_W-1:0] = ref_per_r;
      default:    rd_mux = '0;
    endcase
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // output divider
  // ---------------------------------------------------------------
  clk_out_divider u_div (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .tick_i    (src_tick),
    .output_divider_select_i    (output_divider_select_r),
    .clk_o     (sys_clk_o),
    .clk_en_o  (sys_clk_en_o)
  );

endmodule
`default_nettype wire

// >>> tb/pll_clock_config_props.sv
// Purpose: port-level checks of the clock configuration block
// Assumes: one sys_clk_i domain, nrst_i asynchronous and active low
// Notes:   enable and divider select are shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
module pll_clock_config_props
  import pll_clock_config_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              osc_clk_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] rdata_o,
  input  wire logic              irq_o,
  input  wire logic              sys_clk_o,
  input  wire logic              sys_clk_en_o,
  input  wire logic              locked_o,
  input  wire logic              emergency_o
);
  logic [STS_W-1:0] en_r;
  logic [2:0]       kd_r;
  logic [10:0]      gap_r;
  logic             osc_q_r;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) en_r <= '0;
    else if (wr_i && addr_i == OFS_ENABLE) en_r <= wdata_i[STS_W-1:0];
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) kd_r <= OUTPUT_DIVIDER_SELECT_RESET;
    else if (wr_i && addr_i == OFS_CONFIG) kd_r <= wdata_i[CFG_OUTPUT_DIVIDER_SELECT_LSB+:3];
  end
  // saturates so a long stop never wraps back under the limit
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_q_r <= 1'b0;
      gap_r   <= 11'h000;
    end else begin
      osc_q_r <= osc_clk_i;
      if (osc_clk_i && !osc_q_r) gap_r <= 11'h000;
      else if (gap_r != 11'h7FF) gap_r <= gap_r + 11'h001;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_cfg_rd;
    rd_i && addr_i == OFS_CONFIG;
  endsequence
  sequence s_en_rd;
    rd_i && addr_i == OFS_ENABLE;
  endsequence

  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data left standing");
  a_n_factor: assert property (s_cfg_rd ##1 (rdata_o[CFG_N_LSB+:4] != 4'h0)
    |-> rdata_o[CFG_N_LSB+:4] == N_BASE + {1'b0, rdata_o[CFG_SEL_LSB+:3]})
    else $error("feedback factor does not match select");
  a_output_divider_select_back: assert property (s_cfg_rd |=> rdata_o[CFG_OUTPUT_DIVIDER_SELECT_LSB+:3] == kd_r)
    else $error("divider select readback wrong");
  a_enable_back: assert property (s_en_rd |=> rdata_o[STS_W-1:0] == en_r)
    else $error("enable readback wrong");
  a_irq_masked: assert property ((en_r == '0) [*2] |-> !irq_o)
    else $error("interrupt with nothing enabled");
  a_unlock_emerg: assert property ($fell(locked_o) |-> emergency_o)
    else $error("lock dropped without emergency");
  a_emerg_unlocked: assert property (emergency_o |-> !locked_o)
    else $error("emergency while locked");
  a_clken_high: assert property (sys_clk_en_o |-> sys_clk_o)
    else $error("period start without high level");
  a_clken_pulse: assert property (sys_clk_en_o |=> !sys_clk_en_o)
    else $error("period start longer than one cycle");
  a_loss_unlock: assert property (gap_r > 11'(LOSS_CYCLES + 8) |-> !locked_o)
    else $error("still locked with oscillator gone");
endmodule
`default_nettype wire

// >>> tb/osc_source.sv
// Purpose: oscillator pin model feeding the clock block
// Assumes: the bench starts, stops and slows it
// Notes:   held low while stopped, a halted crystal gives no edges
`timescale 1ns/1ns
`default_nettype none
module osc_source #(
  parameter int HALF_NS = 32
) (
  input  wire logic run_i,
  input  wire logic slow_i,
  output var  logic osc_o
);
  // ---------------------------------------------------------------
  // waveform, 64 ns or 80 ns period, both under 16 MHz
  // ---------------------------------------------------------------
  always begin
    if (run_i) begin
      #(slow_i ? HALF_NS + 8 : HALF_NS) osc_o = 1'b1;
      #(slow_i ? HALF_NS + 8 : HALF_NS) osc_o = 1'b0;
    end else begin
      osc_o = 1'b0;
      @(posedge run_i);
      // off the system edges so sampling never races
      #1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/test_pll_clock_config.sv
// Purpose: self-checking bench for the clock configuration block
// Assumes: oscillator period of 16 system clocks
// Notes:   bypass runs give exact counts, locked runs allow tick jitter
`timescale 1ns/1ns
`default_nettype none
module test_pll_clock_config;
  import pll_clock_config_pkg::*;
  localparam int HALF_NS = 32;
  localparam int OSC_CYC = HALF_NS / 2;
  typedef struct {
    logic [2:0] code;
    int         k;
  } row_t;
  row_t rows [8] = '{'{3'h0, 2}, '{3'h1, 16}, '{3'h2, 4}, '{3'h3, 5},
                     '{3'h4, 6}, '{3'h5, 8}, '{3'h6, 9}, '{3'h7, 10}};
  logic              sys_clk    = 1'b0;
  logic              nrst       = 1'b0;
  logic              run        = 1'b0;
  logic              slow       = 1'b0;
  logic [2:0]        sel        = 3'h0;
  logic              byp        = 1'b0;
  logic [ADDR_W-1:0] addr       = 8'h00;
  logic [DATA_W-1:0] wdata      = 32'h0000_0000;
  logic              wr         = 1'b0;
  logic              rd         = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic              sclk;
  logic              sclk_en;
  logic              locked;
  logic              emer;
  logic              osc;
  logic [DATA_W-1:0] d;
  int                mismatches = 0;
  int                checks     = 0;
  int                per;
  int                hi;
  int                sum;

  always #2 sys_clk = ~sys_clk;

  osc_source #(.HALF_NS(HALF_NS)) u_osc (.run_i(run), .slow_i(slow), .osc_o(osc));
  pll_clock_config dut (
    .sys_clk_i(sys_clk), .nrst_i(nrst), .osc_clk_i(osc), .pll_multiplier_select_i(sel),
    .bypass_i(byp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .sys_clk_o(sclk), .sys_clk_en_o(sclk_en),
    .locked_o(locked), .emergency_o(emer)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask
  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask
  // s: 0 locked, 1 emergency, 2 period start
  task automatic wt(input int s, input int lim);
    logic f;
    for (int i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      f = (s == 0) ? locked : (s == 1) ? emer : sclk_en;
      if (f === 1'b1) return;
    end
    mismatches++;
    $display("[FAIL] %0t wait %h limit %h", $time, s, lim);
    print_verdict;
  endtask
  task automatic meas(output int p, output int h);
    p = 0;
    h = 0;
    do begin
      @(posedge sys_clk);
      #1;
      p++;
      h += int'(sclk === 1'b1);
    end while (sclk_en !== 1'b1 && p < 600);
    if (sclk_en !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t wait %h limit %h", $time, 2, p);
      print_verdict;
    end
  endtask
  task automatic do_reset(input logic [2:0] s, input logic b);
    if (nrst) @(posedge sys_clk);
    nrst <= 1'b0;
    sel  <= s;
    byp  <= b;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    do_reset(3'h5, 1'b1);
    run <= 1'b1;
    bus_rd(OFS_CONFIG, d);
    chk({20'h0, d[11:0]}, 32'h0000_0D0D);
    bus_wr(OFS_CONFIG, 32'hFFFF_FF8F);
    bus_rd(OFS_CONFIG, d);
    chk({20'h0, d[11:0]}, 32'h0000_0D0D);
    bus_rd(8'h20, d);
    chk(d, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[j]) begin
      bus_wr(OFS_CONFIG, {25'h0, rows[j].code, 4'h0});
      wt(2, 600);
      meas(per, hi);
      meas(per, hi);
      chk_n(per, rows[j].k * OSC_CYC);
      chk_n(hi, rows[j].k / 2 * OSC_CYC);
    end
    $display("test divider done");
    do_reset(3'h7, 1'b0);
    bus_wr(OFS_CONFIG, 32'h0000_0010);
    wt(0, 2000);
    bus_rd(OFS_CONFIG, d);
    chk({18'h0, d[13:0]}, 32'h0000_1F17);
    bus_rd(OFS_PERIOD, d);
    chk(d, 32'(OSC_CYC));
    wt(2, 600);
    meas(per, hi);
    sum = 0;
    repeat (15) begin
      meas(per, hi);
      sum += per;
    end
    chk_n(int'(sum > 16 * OSC_CYC - 4 && sum < 16 * OSC_CYC + 4), 1);
    $display("test lock done");
    bus_wr(OFS_CLEAR, 32'h0000_0007);
    slow <= 1'b1;
    wt(1, 300);
    bus_rd(OFS_STATUS, d);
    chk(d, 32'h0000_0006);
    chk({31'h0, irq}, 32'h0000_0000);
    slow <= 1'b0;
    wt(0, 2000);
    $display("test deviation done");
    bus_wr(OFS_CLEAR, 32'h0000_0007);
    run <= 1'b0;
    wt(1, 400);
    chk({30'h0, locked, irq}, 32'h0000_0000);
    bus_wr(OFS_ENABLE, 32'h0000_0001);
    bus_rd(OFS_STATUS, d);
    chk(d, 32'h0000_0005);
    chk({31'h0, irq}, 32'h0000_0001);
    run <= 1'b1;
    wt(0, 2000);
    bus_wr(OFS_CLEAR, 32'h0000_0007);
    bus_rd(OFS_STATUS, d);
    chk({30'h0, emer, irq}, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    $display("test loss done");
    print_verdict;
  end
endmodule

bind pll_clock_config pll_clock_config_props u_props (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .osc_clk_i(osc_clk_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .sys_clk_o(sys_clk_o), .sys_clk_en_o(sys_clk_en_o), .locked_o(locked_o),
  .emergency_o(emergency_o)
);
`default_nettype wire
